// file: design/gims_params.svh
// Purpose: Offsets, field positions, reset values and timing counts of the mask block
// Assumes: Core clock of 125 MHz
// Notes:   Definitions only
`ifndef GIMS_PARAMS_SVH
`define GIMS_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets and codes
// ----------------------------------------------------------------
`define GIMS_OFS_UPPER_MASK   8'h06
`define GIMS_OFS_LOWER_MASK   8'h07
`define GIMS_OFS_SOFT_RESET   8'h7F
`define GIMS_SOFT_RESET_CODE  8'h00
`define GIMS_MASK_RESET       10'h000
`define GIMS_UPPER_LSB        4
`define GIMS_UPPER_W          6
`define GIMS_LOWER_W          4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GIMS_CLK_PERIOD_NS    8
`define GIMS_DEBOUNCE_NS      8000
`define GIMS_DEBOUNCE_CYC     ((`GIMS_DEBOUNCE_NS + `GIMS_CLK_PERIOD_NS - 1) / `GIMS_CLK_PERIOD_NS)

`endif

// file: design/gims_pkg.sv
// Purpose: Types shared by the mask block
// Assumes: Nothing beyond the params header
// Notes:   Command word carried from the link domain to the core
package gims_pkg;

  // Register access command held stable across the crossing
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gims_cmd_t;

endpackage

// file: design/gims_top.sv
// Purpose: Per-channel interrupt masks, software reset and chip identity for ten channels
// Assumes: Register commands come from the serial engine on link_clk_in
// Notes:   Command crosses by toggle handshake; pins pass two flip-flops
`include "gims_params.svh"

module gims_top #(
  parameter int          NUM_CH      = 10,
  parameter int          DEB_CYCLES  = `GIMS_DEBOUNCE_CYC,
  parameter logic [7:0]  CHIP_ID     = 8'hA5  // Arbitrary identity value
) (
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  input  wire logic                 link_clk_in,
  input  wire logic                 link_reset_n_in,
  input  wire logic                 lnk_req_in,
  input  wire gims_pkg::gims_cmd_t  lnk_cmd_in,
  input  wire logic [NUM_CH-1:0]    dir_in,
  input  wire logic [NUM_CH-1:0]    pin_in,
  input  wire logic                 irq_clear_in,
  output logic                      lnk_busy_out,
  output logic                      lnk_done_out,
  output logic [7:0]                lnk_rdata_out,
  output logic [NUM_CH-1:0]         gpio_state_out,
  output logic                      soft_reset_out,
  output logic                      irq_out_low
);
  import gims_pkg::*;

  localparam int                CW       = $clog2(DEB_CYCLES + 1);
  localparam logic [NUM_CH-1:0] MASK_RST = `GIMS_MASK_RESET;

  // Elaboration checks: the mask layout fixes the channel count
  if (NUM_CH != `GIMS_UPPER_LSB + `GIMS_UPPER_W) begin : g_bad_num_ch
    $error("NUM_CH must match the mask register layout");
  end
  if (DEB_CYCLES < 1) begin : g_bad_deb
    $error("DEB_CYCLES must be at least one");
  end

  // ----------------------------------------------------------------
  // Link domain: accept a command, hold it, wait for the answer
  // ----------------------------------------------------------------
  gims_cmd_t   lnk_cmd_q;
  logic        lnk_req_tgl_q;
  logic [1:0]  lnk_ack_sync_q;
  logic        lnk_ack_seen_q;
  logic        lnk_ack_edge;
  logic        core_ack_tgl_q;
  logic [7:0]  core_rdata_q;

  assign lnk_ack_edge = lnk_ack_sync_q[1] ^ lnk_ack_seen_q;

  // Command is frozen while busy so the core may read it without resync
  always_ff @(posedge link_clk_in) begin
    if (!link_reset_n_in) begin
      lnk_cmd_q     <= '0;
      lnk_req_tgl_q <= 1'b0;
      lnk_busy_out  <= 1'b0;
    end else if (lnk_req_in && !lnk_busy_out) begin
      lnk_cmd_q     <= lnk_cmd_in;
      lnk_req_tgl_q <= ~lnk_req_tgl_q;
      lnk_busy_out  <= 1'b1;
    end else if (lnk_ack_edge) begin
      lnk_busy_out  <= 1'b0;
    end
  end

  // Answer toggle synchroniser and read data capture
  always_ff @(posedge link_clk_in) begin
    if (!link_reset_n_in) begin
      lnk_ack_sync_q <= 2'b00;
      lnk_ack_seen_q <= 1'b0;
      lnk_done_out   <= 1'b0;
      lnk_rdata_out  <= 8'h00;
    end else begin
      lnk_ack_sync_q <= {lnk_ack_sync_q[0], core_ack_tgl_q};
      lnk_ack_seen_q <= lnk_ack_sync_q[1];
      lnk_done_out   <= lnk_ack_edge;
      if (lnk_ack_edge) begin
        lnk_rdata_out <= core_rdata_q;  // Stable until the next request
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: request synchroniser and register decode
  // ----------------------------------------------------------------
  logic [1:0]  req_sync_q;
  logic        req_seen_q;
  logic        exec;
  logic        exec_wr;
  logic        soft_wr;
  logic [`GIMS_UPPER_W-1:0] upper_mask_q;
  logic [`GIMS_LOWER_W-1:0] lower_mask_q;
  logic [NUM_CH-1:0]        mask_all;

  assign exec     = req_sync_q[1] ^ req_seen_q;
  assign exec_wr  = exec && lnk_cmd_q.wr;
  assign soft_wr  = exec_wr && (lnk_cmd_q.addr == `GIMS_OFS_SOFT_RESET)
                    && (lnk_cmd_q.wdata == `GIMS_SOFT_RESET_CODE);
  assign mask_all = {upper_mask_q, lower_mask_q};

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      req_sync_q     <= 2'b00;
      req_seen_q     <= 1'b0;
      core_ack_tgl_q <= 1'b0;
    end else begin
      req_sync_q <= {req_sync_q[0], lnk_req_tgl_q};
      req_seen_q <= req_sync_q[1];
      if (exec) begin
        core_ack_tgl_q <= ~core_ack_tgl_q;
      end
    end
  end

  // Mask registers; software reset takes priority over a plain write
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || soft_wr) begin
      upper_mask_q <= MASK_RST[NUM_CH-1:`GIMS_UPPER_LSB];
      lower_mask_q <= MASK_RST[`GIMS_LOWER_W-1:0];
    end else if (exec_wr && lnk_cmd_q.addr == `GIMS_OFS_UPPER_MASK) begin
      upper_mask_q <= lnk_cmd_q.wdata[`GIMS_UPPER_W-1:0];
    end else if (exec_wr && lnk_cmd_q.addr == `GIMS_OFS_LOWER_MASK) begin
      lower_mask_q <= lnk_cmd_q.wdata[`GIMS_LOWER_W-1:0];
    end
  end

  // Soft reset pulse lets the neighbouring registers return to defaults too
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= soft_wr;
    end
  end

  // Read data; reserved bits and unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      core_rdata_q <= 8'h00;
    end else if (exec && !lnk_cmd_q.wr) begin
      case (lnk_cmd_q.addr)
        `GIMS_OFS_UPPER_MASK: core_rdata_q <= {2'b00, upper_mask_q};
        `GIMS_OFS_LOWER_MASK: core_rdata_q <= {4'h0, lower_mask_q};
        `GIMS_OFS_SOFT_RESET: core_rdata_q <= CHIP_ID;
        default:              core_rdata_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input debounce and change detection
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] chg_ev;
  logic [NUM_CH-1:0] pend_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      logic [1:0]    sync_q;
      logic [CW-1:0] cnt_q;

      // On an input channel a level must hold for the full debounce time before it counts
      always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
          sync_q             <= 2'b00;
          cnt_q              <= '0;
          gpio_state_out[gi] <= 1'b0;
          chg_ev[gi]         <= 1'b0;
        end else begin
          sync_q     <= {sync_q[0], pin_in[gi]};
          chg_ev[gi] <= 1'b0;
          if (!dir_in[gi]) begin
            // Output channel: track silently, never raise an event
            gpio_state_out[gi] <= sync_q[1];
            cnt_q              <= '0;
          end else if (sync_q[1] == gpio_state_out[gi]) begin
            cnt_q <= '0;
          end else if (cnt_q == CW'(DEB_CYCLES - 1)) begin
            gpio_state_out[gi] <= sync_q[1];
            chg_ev[gi]         <= 1'b1;
            cnt_q              <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pending flags and interrupt pin
  // ----------------------------------------------------------------
  // A change in the same cycle as a clear survives: set wins
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pend_q <= '0;
    end else if (soft_wr || irq_clear_in) begin
      pend_q <= chg_ev;
    end else begin
      pend_q <= pend_q | chg_ev;
    end
  end

  // Masked channels stay pending but never pull the pin
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      irq_out_low <= 1'b1;
    end else begin
      irq_out_low <= ~|(pend_q & ~mask_all);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence sq_wr(logic [7:0] ofs);
    exec_wr && lnk_cmd_q.addr == ofs && !soft_wr;
  endsequence

  sequence sq_id_read;
    exec && !lnk_cmd_q.wr && lnk_cmd_q.addr == `GIMS_OFS_SOFT_RESET;
  endsequence

  AST_UPPER_MASK_WR: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    sq_wr(`GIMS_OFS_UPPER_MASK) |=> upper_mask_q == $past(lnk_cmd_q.wdata[5:0]))
    else $error("upper mask did not take written value");

  AST_LOWER_MASK_WR: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    sq_wr(`GIMS_OFS_LOWER_MASK) |=> lower_mask_q == $past(lnk_cmd_q.wdata[3:0]))
    else $error("lower mask did not take written value");

  AST_MASK_RESET_ZERO: assert property (@(posedge clk_in)
    !reset_n_in |=> mask_all == '0 && irq_out_low)
    else $error("masks not zero after reset");

  AST_SOFT_RESET: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    soft_wr |=> mask_all == '0 && soft_reset_out ##1 !soft_reset_out || soft_wr)
    else $error("software reset did not restore masks");

  AST_ID_READ: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    sq_id_read |=> core_rdata_q == CHIP_ID)
    else $error("identity read returned wrong value");

  AST_OUTPUT_NO_EVENT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (chg_ev & ~$past(dir_in)) == '0)
    else $error("output channel raised a change event");

  AST_IRQ_ENABLED: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (chg_ev & ~mask_all) != '0 && !soft_wr |=> ##1 !irq_out_low)
    else $error("enabled change did not assert interrupt");

  AST_IRQ_MASKED: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (pend_q & ~mask_all) == '0 |=> irq_out_low)
    else $error("interrupt asserted with only masked channels pending");

  AST_LINK_ROUNDTRIP: assert property (@(posedge link_clk_in) disable iff (!link_reset_n_in)
    lnk_req_in && !lnk_busy_out |=> lnk_busy_out ##[1:12] lnk_done_out)
    else $error("link request not answered in time");

endmodule

// file: sim/gims_host_model.sv
// Purpose: Host side of the link register port
// Assumes: One command at a time, taken at a link edge with busy low
// Notes:   Released command lines are inverted so stale values never look valid
module gims_host_model (
  input  wire logic       clk_in,
  input  wire logic       busy_in,
  input  wire logic       done_in,
  input  wire logic [7:0] rdata_in,
  output logic            req_out,
  output gims_pkg::gims_cmd_t cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import gims_pkg::*;

  initial begin
    req_out = 1'b0;
    cmd_out = '0;
  end

  // ----------------------------------------------------------------
  // One access; ok stays low if the answer is late
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] rdata, output logic ok);
    int n;
    logic bsy;
    bsy = 1'b0;
    ok = 1'b0;
    rdata = 8'h00;
    @(posedge clk_in);
    req_out <= 1'b1;
    cmd_out <= '{wr: wr, addr: a, wdata: d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (busy_in !== 1'b0 && n < 12);
    req_out <= 1'b0;
    cmd_out <= ~cmd_out;
    // Bound of 12 link cycles on the answer
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge clk_in);
      // Busy must have been shown before the answer counts
      if (busy_in === 1'b1) begin
        bsy = 1'b1;
      end
      if (done_in === 1'b1) begin
        ok = bsy;
        rdata = rdata_in;
      end
    end
  endtask

  // Software reset is the all-zero code
  task automatic soft_reset(output logic ok);
    logic [7:0] r;
    access(1'b1, 8'h7F, 8'h00, r, ok);
  endtask
endmodule

// file: sim/tb_gpio_irq_mask_soft_reset.sv
// Purpose: Self-checking bench of the mask, reset and identity block
// Assumes: Short debounce count for a quick run
// Notes:   Link clock free-running, offset in phase from the core clock
`include "gims_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_gpio_irq_mask_soft_reset;
  import gims_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         DEB = 4;
  localparam int         SETTLE = DEB + 10;
  localparam logic [7:0] ID = 8'h5C; // Arbitrary identity value
  logic clk_in = 0, link_clk = 0, reset_n = 0, link_rst_n = 0, irq_clr = 0;
  logic req, busy, done, sr, irq_n;
  logic [7:0] rdata;
  logic [9:0] dir = 10'h3FF, pin = 10'h000, state;
  gims_cmd_t cmd;
  int n_fail = 0, checks = 0, n_sr = 0;

  always #4 clk_in = ~clk_in;
  initial begin
    #5;
    forever #32 link_clk = ~link_clk;
  end
  // Count soft reset pulses
  always @(posedge clk_in) if (sr === 1'b1) n_sr++;

  gims_top #(.DEB_CYCLES(DEB), .CHIP_ID(ID)) u_dut (
    .clk_in(clk_in), .reset_n_in(reset_n), .link_clk_in(link_clk),
    .link_reset_n_in(link_rst_n), .lnk_req_in(req), .lnk_cmd_in(cmd),
    .dir_in(dir), .pin_in(pin), .irq_clear_in(irq_clr), .lnk_busy_out(busy),
    .lnk_done_out(done), .lnk_rdata_out(rdata), .gpio_state_out(state),
    .soft_reset_out(sr), .irq_out_low(irq_n));
  gims_host_model u_host (.clk_in(link_clk), .busy_in(busy), .done_in(done),
    .rdata_in(rdata), .req_out(req), .cmd_out(cmd));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic ok;
    u_host.access(1'b1, a, d, r, ok);
    `CHK("write done", 1'b1, ok)
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    logic ok;
    u_host.access(1'b0, a, 8'h00, r, ok);
    `CHK("read done", 1'b1, ok)
    `CHK("read data", e, r)
  endtask
  task automatic clear();
    @(posedge clk_in);
    irq_clr <= 1'b1;
    @(posedge clk_in);
    irq_clr <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK("irq idle", 1'b1, irq_n)
    rd(`GIMS_OFS_UPPER_MASK, 8'h00);
    rd(`GIMS_OFS_LOWER_MASK, 8'h00);
    rd(`GIMS_OFS_SOFT_RESET, ID);
    rd(8'h10, 8'h00);
    wr(`GIMS_OFS_UPPER_MASK, 8'hFF);
    wr(`GIMS_OFS_LOWER_MASK, 8'hFF);
    rd(`GIMS_OFS_UPPER_MASK, 8'h3F);
    rd(`GIMS_OFS_LOWER_MASK, 8'h0F);
    $display("test reset done");
  endtask
  // Each channel alone unmasked; its neighbour must stay silent
  task automatic t_mask_map();
    int i;
    logic [9:0] m;
    for (i = 0; i < 10; i++) begin
      m = ~(10'h001 << i);
      wr(`GIMS_OFS_LOWER_MASK, {4'h0, m[3:0]});
      wr(`GIMS_OFS_UPPER_MASK, {2'h0, m[9:4]});
      clear();
      pin <= pin ^ (10'h001 << ((i + 1) % 10));
      repeat (SETTLE) @(posedge clk_in);
      `CHK("masked channel", 1'b1, irq_n)
      `CHK("input state", pin, state)
      pin <= pin ^ (10'h001 << i);
      repeat (SETTLE) @(posedge clk_in);
      `CHK("unmasked channel", 1'b0, irq_n)
    end
    $display("test mask map done");
  endtask
  task automatic t_dir();
    wr(`GIMS_OFS_LOWER_MASK, 8'h00);
    wr(`GIMS_OFS_UPPER_MASK, 8'h00);
    clear();
    dir <= 10'h3FE;
    pin <= pin ^ 10'h001;
    repeat (SETTLE) @(posedge clk_in);
    `CHK("output channel silent", 1'b1, irq_n)
    `CHK("output channel level", pin[0], state[0])
    dir <= 10'h3FF;
    pin <= pin ^ 10'h001;
    repeat (SETTLE) @(posedge clk_in);
    `CHK("input channel raises", 1'b0, irq_n)
    clear();
    $display("test direction done");
  endtask
  // Masked pending change must be wiped by the software reset
  task automatic t_soft();
    logic ok;
    wr(`GIMS_OFS_UPPER_MASK, 8'h2A);
    wr(`GIMS_OFS_LOWER_MASK, 8'h05);
    @(posedge clk_in);
    pin <= pin ^ 10'h020;
    repeat (SETTLE) @(posedge clk_in);
    `CHK("masked pending silent", 1'b1, irq_n)
    wr(`GIMS_OFS_SOFT_RESET, 8'h55);
    rd(`GIMS_OFS_UPPER_MASK, 8'h2A);
    `CHK("no pulse on other code", 0, n_sr)
    u_host.soft_reset(ok);
    `CHK("soft reset done", 1'b1, ok)
    repeat (4) @(posedge clk_in);
    `CHK("soft reset pulse", 1, n_sr)
    rd(`GIMS_OFS_UPPER_MASK, 8'h00);
    rd(`GIMS_OFS_LOWER_MASK, 8'h00);
    `CHK("pending wiped", 1'b1, irq_n)
    rd(`GIMS_OFS_SOFT_RESET, ID);
    $display("test soft reset done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected 20 us of traffic
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge link_clk);
    link_rst_n <= 1'b1;
    @(posedge clk_in);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_reset();
    t_mask_map();
    t_dir();
    t_soft();
    final_report();
  end
endmodule
